/* File: hw/psce_defines.vh */
// Constants shared by the potentiometer serial command executor.
`ifndef PSCE_DEFINES_VH
`define PSCE_DEFINES_VH

// EEPROM write cycle time in system clocks: 5 ms at 100 MHz.
// Sized to the 20-bit counter so that no bits are cut on use.
`define PSCE_TWC_CYCLES 20'h7A120

// Location addresses.
`define PSCE_ADDR_WIPER0 4'h0
`define PSCE_ADDR_WIPER1 4'h1
`define PSCE_ADDR_STATUS 4'h4
`define PSCE_ADDR_TERMINAL_CONTROL_REGISTER 4'h5

// Opcodes.
`define PSCE_OP_WRITE 2'h0
`define PSCE_OP_INCR 2'h1
`define PSCE_OP_DECR 2'h2
`define PSCE_OP_READ 2'h3

// Clock counts within a frame.
`define PSCE_BITS_ADDR 5'h04
`define PSCE_BITS_CMD 5'h06
`define PSCE_BITS_STEP 5'h08
`define PSCE_BITS_DOUT_LAST 5'h0F
`define PSCE_BITS_LONG 5'h10

// Field positions in the shifted command.
`define PSCE_CMD_ADDR_HI 5
`define PSCE_CMD_ADDR_LO 2
`define PSCE_CMD_OP_HI 1
`define PSCE_CMD_OP_LO 0
`define PSCE_DATA_HI 8
`define PSCE_STAT_EEPROM_WRITE_ACTIVE_FLAG_BIT 4

// Wiper scale limits and reset values.
`define PSCE_FULL_SCALE 9'h100
`define PSCE_ZERO_SCALE 9'h000
`define PSCE_WIPER_RST 9'h080
`define PSCE_TERMINAL_CONTROL_REGISTER_RST 9'h1FF
`define PSCE_STAT_RST 9'h000
`define PSCE_MEM_RST 9'h000
`define PSCE_DOUT_BAD 9'h1FF

`endif

/* File: hw/psce_mem.v */
// Sixteen-word non-volatile image with a registered read port.
`timescale 1ns/100ps
`default_nettype none
`include "psce_defines.vh"
module psce_mem (
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire we_i,
  input wire [3:0] waddr_i,
  input wire [8:0] wdata_i,
  input wire [3:0] raddr_i,
  output reg [8:0] rdata_o
);
  reg [8:0] mem [0:15];
  integer i;

  // Stores a word on a write strobe and registers the read word.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      for (i = 0; i < 16; i = i + 1) begin
        mem[i] <= `PSCE_MEM_RST;
      end
      rdata_o <= `PSCE_MEM_RST;
    end else if (ce_i) begin
      if (we_i) begin
        mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
    end
  end
endmodule
`default_nettype wire

/* File: hw/psce_top.v */
// Serial command executor of a digital potentiometer.
`timescale 1ns/100ps
`default_nettype none
`include "psce_defines.vh"
module psce_top #(
  parameter [19:0] TWC_CYCLES = `PSCE_TWC_CYCLES
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire cs_b_i,
  input wire sck_i,
  input wire sdi_i,
  output reg sdo_o,
  output reg sdo_oe_b_o,
  output reg [8:0] wiper0_o,
  output reg [8:0] wiper1_o,
  output reg [8:0] terminal_control_register_o,
  output reg eeprom_write_active_flag_o,
  output reg command_error_bit_o
);

  // Synchroniser stages for the link pins.
  reg cs_s1;
  reg cs_s2;
  reg cs_d;
  reg sck_s1;
  reg sck_s2;
  reg sck_d;
  reg sdi_s1;
  reg sdi_s2;

  // Frame state.
  reg [4:0] cnt;
  reg [15:0] shift;
  reg [3:0] addr;
  reg [1:0] op;
  reg [3:0] rd_addr;
  reg [8:0] rd_sh;
  reg nv_done;
  reg nv_pend;
  reg [3:0] nv_addr;
  reg [8:0] nv_data;

  // EEPROM write cycle state.
  reg [19:0] twc_cnt;
  reg mem_we;

  // Derived values.
  reg [4:0] next_cnt;
  reg [15:0] next_shift;
  reg [8:0] status;
  reg [8:0] next_rd;
  wire [8:0] mem_rdata;
  wire cs_act;
  wire cs_rise;
  wire sck_rise;
  wire sck_fall;
  wire at_cmd;
  wire bad_now;
  wire step_end;
  wire step_go;
  wire long_end;
  wire wr_go;
  wire wr_vol;
  wire wr_nv;
  wire [3:0] new_addr;
  wire [1:0] new_op;

  // True for locations that live in volatile storage.
  function is_vol;
    input [3:0] a;
    begin
      is_vol = (a == `PSCE_ADDR_WIPER0) || (a == `PSCE_ADDR_WIPER1) ||
               (a == `PSCE_ADDR_STATUS) || (a == `PSCE_ADDR_TERMINAL_CONTROL_REGISTER);
    end
  endfunction

  // True for the two wiper locations.
  function is_wiper;
    input [3:0] a;
    begin
      is_wiper = (a == `PSCE_ADDR_WIPER0) || (a == `PSCE_ADDR_WIPER1);
    end
  endfunction

  // True for the increment and decrement opcodes.
  function is_step;
    input [1:0] o;
    begin
      is_step = (o == `PSCE_OP_INCR) || (o == `PSCE_OP_DECR);
    end
  endfunction

  // Steps a wiper by one with saturation and range inhibit.
  function [8:0] step_wiper;
    input [8:0] w;
    input up;
    begin
      step_wiper = w;
      if (up) begin
        if (w < `PSCE_FULL_SCALE) begin
          step_wiper = w + 9'h001;
        end
      end else if ((w <= `PSCE_FULL_SCALE) &&
                   (w != `PSCE_ZERO_SCALE)) begin
        step_wiper = w - 9'h001;
      end
    end
  endfunction

  // Two flip-flops on every link pin before any logic reads it.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_d <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_d <= 1'b0;
      sdi_s1 <= 1'b0;
      sdi_s2 <= 1'b0;
    end else if (ce_i) begin
      cs_s1 <= cs_b_i;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
      sck_s1 <= sck_i;
      sck_s2 <= sck_s1;
      sck_d <= sck_s2;
      sdi_s1 <= sdi_i;
      sdi_s2 <= sdi_s1;
    end
  end

  // Select level and serial clock edges seen in the system clock.
  assign cs_act = ~cs_s2;
  assign cs_rise = cs_s2 & ~cs_d;
  assign sck_rise = cs_act & sck_s2 & ~sck_d;
  assign sck_fall = cs_act & ~sck_s2 & sck_d;

  // Clock count and shift value after the current rising edge.
  always @* begin
    next_cnt = cnt + 5'h01;
    next_shift = {shift[14:0], sdi_s2};
  end

  // Address and opcode sit in the first six bits of a frame.
  assign new_addr = next_shift[`PSCE_CMD_ADDR_HI:`PSCE_CMD_ADDR_LO];
  assign new_op = next_shift[`PSCE_CMD_OP_HI:`PSCE_CMD_OP_LO];
  assign at_cmd = sck_rise & (next_cnt == `PSCE_BITS_CMD);

  // A command is refused after a non-volatile write, while busy on a
  // non-volatile location, or as a step to a non-wiper address.
  assign bad_now = command_error_bit_o | nv_done |
                   (eeprom_write_active_flag_o & ~is_vol(new_addr)) |
                   (is_step(new_op) & ~is_wiper(new_addr));

  // Frame end points and the actions taken there.
  assign step_end = sck_rise & (next_cnt == `PSCE_BITS_STEP) & is_step(op);
  assign step_go = step_end & ~command_error_bit_o;
  assign long_end = sck_rise & (next_cnt == `PSCE_BITS_LONG);
  assign wr_go = long_end & (op == `PSCE_OP_WRITE) & ~command_error_bit_o;
  assign wr_vol = wr_go & is_vol(addr);
  assign wr_nv = wr_go & ~is_vol(addr);

  // Frame counter and shifter; a step frame ends after eight clocks,
  // a read or write after sixteen, and the next frame starts at once.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt <= 5'h00;
      shift <= 16'h0000;
      addr <= 4'h0;
      op <= `PSCE_OP_WRITE;
      rd_addr <= 4'h0;
    end else if (ce_i) begin
      if (!cs_act) begin
        cnt <= 5'h00;
      end else if (sck_rise) begin
        shift <= next_shift;
        if (step_end || long_end) begin
          cnt <= 5'h00;
        end else begin
          cnt <= next_cnt;
        end
        if (next_cnt == `PSCE_BITS_ADDR) begin
          rd_addr <= next_shift[3:0];
        end
        if (at_cmd) begin
          addr <= new_addr;
          op <= new_op;
        end
      end
    end
  end

  // Command error stays set until select goes inactive; a pending
  // non-volatile write is dropped by any clock after its sixteenth.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      command_error_bit_o <= 1'b0;
      nv_done <= 1'b0;
      nv_pend <= 1'b0;
      nv_addr <= 4'h0;
      nv_data <= 9'h000;
    end else if (ce_i) begin
      if (!cs_act) begin
        command_error_bit_o <= 1'b0;
        nv_done <= 1'b0;
        nv_pend <= 1'b0;
      end else if (sck_rise) begin
        if (at_cmd && bad_now) begin
          command_error_bit_o <= 1'b1;
        end
        if (nv_done) begin
          nv_pend <= 1'b0;
        end
        if (wr_nv) begin
          nv_done <= 1'b1;
          nv_pend <= 1'b1;
          nv_addr <= addr;
          nv_data <= next_shift[`PSCE_DATA_HI:0];
        end
      end
    end
  end

  // Volatile locations: wipers take writes and steps, control takes
  // writes, the status location ignores writes.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wiper0_o <= `PSCE_WIPER_RST;
      wiper1_o <= `PSCE_WIPER_RST;
      terminal_control_register_o <= `PSCE_TERMINAL_CONTROL_REGISTER_RST;
    end else if (ce_i) begin
      if (step_go && (addr == `PSCE_ADDR_WIPER0)) begin
        wiper0_o <= step_wiper(wiper0_o, op == `PSCE_OP_INCR);
      end
      if (step_go && (addr == `PSCE_ADDR_WIPER1)) begin
        wiper1_o <= step_wiper(wiper1_o, op == `PSCE_OP_INCR);
      end
      if (wr_vol && (addr == `PSCE_ADDR_WIPER0)) begin
        wiper0_o <= next_shift[`PSCE_DATA_HI:0];
      end
      if (wr_vol && (addr == `PSCE_ADDR_WIPER1)) begin
        wiper1_o <= next_shift[`PSCE_DATA_HI:0];
      end
      if (wr_vol && (addr == `PSCE_ADDR_TERMINAL_CONTROL_REGISTER)) begin
        terminal_control_register_o <= next_shift[`PSCE_DATA_HI:0];
      end
    end
  end

  // EEPROM cycle: starts on deselect when a clean write is pending,
  // then holds the busy flag for the write cycle time.
  // The start is placed last so that it wins over the countdown if a
  // new deselect lands in the cycle in which the old one expires.
  // The count holds the remaining cycles; it reaches one in the final
  // cycle, so the flag stands for exactly TWC_CYCLES clocks.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      twc_cnt <= 20'h00000;
      eeprom_write_active_flag_o <= 1'b0;
      mem_we <= 1'b0;
    end else if (ce_i) begin
      mem_we <= 1'b0;
      if (eeprom_write_active_flag_o) begin
        twc_cnt <= twc_cnt - 20'h00001;
        if (twc_cnt == 20'h00001) begin
          eeprom_write_active_flag_o <= 1'b0;
        end
      end
      if (cs_rise && nv_pend) begin
        mem_we <= 1'b1;
        eeprom_write_active_flag_o <= 1'b1;
        twc_cnt <= TWC_CYCLES;
      end
    end
  end

  // Non-volatile image. It is written only at the start of an EEPROM
  // cycle and read through a register; the read address is caught on
  // the fourth clock, so the word is settled long before the sixth.
  psce_mem u_mem (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .ce_i(ce_i),
    .we_i(mem_we),
    .waddr_i(nv_addr),
    .wdata_i(nv_data),
    .raddr_i(rd_addr),
    .rdata_o(mem_rdata)
  );

  // Status word carries the busy flag; read data is chosen here.
  // A refused read returns all ones, which also hides non-volatile
  // words while an EEPROM cycle runs.
  always @* begin
    status = `PSCE_STAT_RST;
    status[`PSCE_STAT_EEPROM_WRITE_ACTIVE_FLAG_BIT] = eeprom_write_active_flag_o;
    case (new_addr)
      `PSCE_ADDR_WIPER0: next_rd = wiper0_o;
      `PSCE_ADDR_WIPER1: next_rd = wiper1_o;
      `PSCE_ADDR_STATUS: next_rd = status;
      `PSCE_ADDR_TERMINAL_CONTROL_REGISTER: next_rd = terminal_control_register_o;
      default: next_rd = mem_rdata;
    endcase
    if (bad_now) begin
      next_rd = `PSCE_DOUT_BAD;
    end
  end

  // Output shifter: error bit after the sixth clock, then nine data
  // bits for a read, each set up on a falling edge, MSB first.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_sh <= 9'h000;
      sdo_o <= 1'b1;
      sdo_oe_b_o <= 1'b1;
    end else if (ce_i) begin
      if (!cs_act) begin
        sdo_o <= 1'b1;
        sdo_oe_b_o <= 1'b1;
      end else if (at_cmd) begin
        rd_sh <= next_rd;
      end else if (sck_fall) begin
        if (cnt == `PSCE_BITS_CMD) begin
          sdo_o <= ~command_error_bit_o;
          sdo_oe_b_o <= 1'b0;
        end else if ((op == `PSCE_OP_READ) &&
                     (cnt > `PSCE_BITS_CMD) &&
                     (cnt <= `PSCE_BITS_DOUT_LAST)) begin
          sdo_o <= rd_sh[8];
          rd_sh <= {rd_sh[7:0], 1'b0};
          sdo_oe_b_o <= 1'b0;
        end else begin
          sdo_o <= 1'b1;
          sdo_oe_b_o <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: tb/psce_host.sv */
// Host serial master model driving select, clock and data.
`timescale 1ns/100ps
`default_nettype none
module psce_host (
  input wire clk_i,
  input wire sdo_i,
  output logic cs_b_o,
  output logic sck_o,
  output logic sdi_o
);
  // Lines start idle with select inactive and the clock low.
  initial begin
    cs_b_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  // Waits a number of falling system clock edges.
  task automatic gap(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // Sends n bits first-out highest and keeps what data out showed per bit.
  task automatic shift(input int n, input logic [15:0] d,
      output logic [15:0] q);
    q = 16'h0000;
    for (int i = n - 1; i >= 0; i--) begin
      sdi_o = d[i];
      gap(4);
      sck_o = 1'b1;
      gap(4);
      q = {q[14:0], sdo_i};
      sck_o = 1'b0;
    end
    sdi_o = ~sdi_o; // Stale data never lingers on the line.
  endtask
  // Selects the device; select then holds for the whole frame.
  task automatic sel();
    cs_b_o = 1'b0;
    gap(4);
  endtask
  // Releases select promptly once the last frame is done.
  task automatic desel();
    gap(2);
    cs_b_o = 1'b1;
    gap(6);
  endtask
endmodule
`default_nettype wire

/* File: tb/psce_props.sv */
// Port checker for the potentiometer serial command executor.
`timescale 1ns/100ps
`default_nettype none
module psce_props #(
  parameter [19:0] TWC_CYCLES = 20'h00032
) (
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  input wire cs_b_i,
  input wire sck_i,
  input wire sdi_i,
  input wire sdo_o,
  input wire sdo_oe_b_o,
  input wire [8:0] wiper0_o,
  input wire [8:0] wiper1_o,
  input wire [8:0] terminal_control_register_o,
  input wire eeprom_write_active_flag_o,
  input wire command_error_bit_o
);
  reg [19:0] busy_cnt;
  // Counts the cycles for which the busy flag has stood.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_cnt <= 20'h00000;
    end else if (eeprom_write_active_flag_o) begin
      busy_cnt <= busy_cnt + 20'h00001;
    end else begin
      busy_cnt <= 20'h00000;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Select held inactive long enough to pass the synchronisers.
  sequence idle_s;
    cs_b_i [*5];
  endsequence
  // The error bit shows low on the driven data line soon after.
  sequence err_out_s;
    ##[0:16] (!sdo_oe_b_o && !sdo_o);
  endsequence
  sdo_release_a: assert property (idle_s |-> sdo_oe_b_o && sdo_o)
    else $error("data out driven while deselected");
  err_clear_a: assert property (idle_s |-> !command_error_bit_o)
    else $error("error flag kept after deselect");
  wiper0_hold_a: assert property (idle_s |=> $stable(wiper0_o))
    else $error("wiper0 moved while deselected");
  wiper1_hold_a: assert property (idle_s |=> $stable(wiper1_o))
    else $error("wiper1 moved while deselected");
  terminal_control_register_hold_a: assert property (idle_s |=> $stable(terminal_control_register_o))
    else $error("terminal_control_register moved while deselected");
  busy_start_a: assert property ($rose(eeprom_write_active_flag_o) |->
    $past(cs_b_i, 2)) else $error("busy began while selected");
  busy_len_a: assert property ($fell(eeprom_write_active_flag_o) |->
    busy_cnt == TWC_CYCLES) else $error("busy length wrong");
  err_drive_a: assert property ($rose(command_error_bit_o) |-> err_out_s)
    else $error("error bit not shown on data out");
endmodule
bind psce_top psce_props #(.TWC_CYCLES(TWC_CYCLES)) u_props (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .cs_b_i(cs_b_i),
  .sck_i(sck_i), .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_b_o(sdo_oe_b_o),
  .wiper0_o(wiper0_o), .wiper1_o(wiper1_o), .terminal_control_register_o(terminal_control_register_o),
  .eeprom_write_active_flag_o(eeprom_write_active_flag_o),
  .command_error_bit_o(command_error_bit_o)
);
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench of the potentiometer serial command executor.
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  wire cs_b_i, sck_i, sdi_i, sdo_o, sdo_oe_b_o;
  wire [8:0] wiper0_o, wiper1_o, terminal_control_register_o;
  wire eeprom_write_active_flag_o, command_error_bit_o;
  wire sdo_w = sdo_oe_b_o ? 1'b1 : sdo_o;
  int err_total = 0;
  int n_checks = 0;
  int m_w[16];
  int vals[5] = '{0, 255, 256, 257, 0};
  logic [15:0] sh[2] = '{16'h00AA, 16'h10AA};
  int err_m = 0, nvw_m = 0, pend_m = 0, busy_m = 0, pa = 0, pd = 0;
  logic [15:0] q;
  psce_top #(.TWC_CYCLES(20'h00258)) uut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .cs_b_i(cs_b_i),
    .sck_i(sck_i), .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_b_o(sdo_oe_b_o),
    .wiper0_o(wiper0_o), .wiper1_o(wiper1_o), .terminal_control_register_o(terminal_control_register_o),
    .eeprom_write_active_flag_o(eeprom_write_active_flag_o),
    .command_error_bit_o(command_error_bit_o)
  );
  psce_host host (.clk_i(clk_i), .sdo_i(sdo_w), .cs_b_o(cs_b_i),
    .sck_o(sck_i), .sdi_o(sdi_i));
  // System clock of 100 MHz.
  always #5 clk_i = ~clk_i;
  // Compares one value and reports a mismatch.
  task automatic chk(input string nm, input logic [8:0] seen,
      input logic [8:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Prints the verdict and ends the run.
  task automatic wrap_up();
    if (err_total == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // Model of one step on a wiper value.
  function automatic int stepv(int v, int up);
    if (v > 256) return v;
    if (up != 0) return (v == 256) ? v : v + 1;
    return (v == 0) ? v : v - 1;
  endfunction
  // Compares the location ports and error flag with the model.
  task automatic chkp();
    chk("wiper0", wiper0_o, m_w[0][8:0]);
    chk("wiper1", wiper1_o, m_w[1][8:0]);
    chk("terminal_control_register", terminal_control_register_o, m_w[5][8:0]);
    chk("cmd err", command_error_bit_o, err_m[8:0]);
  endtask
  // Sends one command frame and checks it against the model.
  task automatic op(input int a, input int o, input int d);
    int n;
    int bad;
    logic [8:0] ex;
    n = (o == 1 || o == 2) ? 8 : 16;
    bad = err_m || nvw_m || (n == 8 && a > 1);
    if (busy_m && !(a inside {0, 1, 4, 5})) bad = 1;
    if (nvw_m) pend_m = 0;
    host.shift(n, n == 8 ? {8'h00, a[3:0], o[1:0], 2'b11} :
      {a[3:0], o[1:0], 1'b1, d[8:0]}, q);
    host.gap(4);
    ex = bad ? 9'h1FF : (a == 4) ? {4'h0, busy_m[0], 4'h0} : m_w[a][8:0];
    chk("err bit", n == 8 ? q[1] : q[9], {8'h00, bad == 0});
    if (o == 3) chk("read", q[8:0], ex);
    if (bad) begin
      err_m = 1;
    end else if (n == 8) begin
      m_w[a] = stepv(m_w[a], o == 1);
    end else if (o == 0 && (a < 2 || a == 5)) begin
      m_w[a] = d;
    end else if (o == 0 && a != 4) begin
      nvw_m = 1;
      pend_m = 1;
      pa = a;
      pd = d;
    end
    chkp();
  endtask
  // Deselects and checks the busy flag and ports.
  task automatic drop();
    host.desel();
    if (pend_m) busy_m = 1;
    err_m = 0;
    nvw_m = 0;
    pend_m = 0;
    chk("busy", eeprom_write_active_flag_o, busy_m[8:0]);
    chkp();
  endtask
  // Walks through the command scenarios in order.
  initial begin
    void'($urandom(32'h019E3DD9));
    vals[4] = $urandom_range(256, 0);
    foreach (m_w[i]) m_w[i] = 0;
    m_w[0] = 128;
    m_w[1] = 128;
    m_w[5] = 511;
    repeat (3) @(negedge clk_i);
    rst_b_i = 1'b1;
    host.gap(6);
    drop();
    foreach (vals[i]) begin
      host.sel();
      op(0, 0, vals[i]);
      op(1, 0, vals[i]);
      op(0, 1, 0);
      op(0, 1, 0);
      op(1, 2, 0);
      op(0, 3, 0);
      op(1, 1, 0);
      drop();
    end
    host.sel();
    op(5, 0, $urandom_range(511, 0));
    op(5, 3, 0);
    drop();
    host.sel();
    op(3, 2, 0);
    op(0, 1, 0);
    drop();
    foreach (sh[i]) begin
      host.sel();
      host.shift(15, sh[i], q);
      drop();
    end
    host.sel();
    op(2, 0, 9'h0F0);
    host.shift(1, 16'h0000, q);
    pend_m = 0;
    drop();
    host.sel();
    op(3, 0, 9'h0AA);
    op(3, 0, 9'h055);
    drop();
    host.sel();
    op(2, 0, 9'h155);
    drop();
    host.sel();
    op(4, 3, 0);
    op(2, 3, 0);
    drop();
    host.sel();
    op(1, 0, $urandom_range(256, 0));
    drop();
    for (int k = 0; k < 900 && eeprom_write_active_flag_o; k++) host.gap(1);
    busy_m = 0;
    m_w[pa] = pd;
    host.sel();
    op(4, 3, 0);
    op(2, 3, 0);
    op(0, 3, 0);
    drop();
    wrap_up();
  end
  // Cuts a hung run short.
  initial begin
    #400000;
    err_total++;
    wrap_up();
  end
endmodule
`default_nettype wire
